// ### logic/tsc_status_map.svh
// Register map, field positions, reset values and timing figures
// for the temperature sensor status and configuration block.
// Assumes the serial interface logic decodes the register pointer.
//
// Notes on behaviour
// - Low flag sets below low limit
// - High and critical flags set above limits
// - Low flag clears on read or recovery
// - High flag clears on read or recovery
// - Critical flag clears on read or recovery
// - Ready bit drops on result write, resets high
// - Temperature read returns ready bit high
// - Mode write in single/slow modes raises ready
// - Alarms need one to four faults
// - Config bit two sets critical polarity
// - Config bit three sets limit polarity
// - Config bit four picks interrupt or comparator
// - Mode zero converts back to back
// - Mode one does one long conversion
// - Mode two converts once each second
// - Mode three idles, registers stay reachable
// - Config bit seven picks result resolution
// - Wide results replace low byte flags
// - Hysteresis widens the release thresholds
`ifndef TSC_STATUS_MAP_SVH
`define TSC_STATUS_MAP_SVH

// Register offsets
`define TSC_REG_TEMP_MSB   8'h00
`define TSC_REG_TEMP_LSB   8'h01
`define TSC_REG_STATUS     8'h02
`define TSC_REG_CONFIG     8'h03

// Reset values
`define TSC_CONFIG_RESET   8'h00
`define TSC_READY_N_RESET  1'b1

// Hysteresis is whole degrees; one degree is this shift of the lsb
`define TSC_HYST_SHIFT     7

// Timing figures in milliseconds and the clock rate in kHz
`define TSC_CLK_KHZ        50000
`define TSC_CONT_CONV_MS   240
`define TSC_ONESHOT_MS     240
`define TSC_SPS_CONV_MS    60
`define TSC_SPS_PERIOD_MS  1000

`endif

// ### logic/tsc_pkg.sv
// Types shared by the temperature sensor status block.
// Assumes tsc_status_map.svh supplies the numeric constants.
package tsc_pkg;

   // Conversion modes held in the configuration field
   typedef enum logic [1:0] {
      TSC_MODE_CONT    = 2'b00,
      TSC_MODE_ONESHOT = 2'b01,
      TSC_MODE_SPS     = 2'b10,
      TSC_MODE_SHUTDN  = 2'b11
   } tsc_mode_t;

   // Configuration register layout, bit 7 down to bit 0
   typedef struct packed {
      logic       res16;
      tsc_mode_t  mode;
      logic       cmp_mode;
      logic       limit_pol;
      logic       crit_pol;
      logic [1:0] fault_q;
   } tsc_cfg_t;

   // Limit values from the setpoint registers
   typedef struct packed {
      logic [15:0] high;
      logic [15:0] low;
      logic [15:0] crit;
      logic [3:0]  hysteresis_value;
   } tsc_limits_t;

   // Conversion sequencer states
   typedef enum logic [1:0] {
      TSC_SEQ_OFF  = 2'b00,
      TSC_SEQ_CONV = 2'b01,
      TSC_SEQ_REST = 2'b10
   } tsc_seq_state_t;

endpackage

// ### logic/tsc_conv_seq.sv
// Conversion sequencer: paces conversions for the selected mode.
// Assumes the conversion engine runs while conv_active is high.
`timescale 1ns/1ps
`include "tsc_status_map.svh"
module tsc_conv_seq #(
   parameter int unsigned CONT_CYC    = `TSC_CONT_CONV_MS * `TSC_CLK_KHZ,
   parameter int unsigned ONESHOT_CYC = `TSC_ONESHOT_MS * `TSC_CLK_KHZ,
   parameter int unsigned SPS_CYC     = `TSC_SPS_CONV_MS * `TSC_CLK_KHZ,
   parameter int unsigned PERIOD_CYC  = `TSC_SPS_PERIOD_MS * `TSC_CLK_KHZ
) (
   input  wire logic            clk,
   input  wire logic            reset,
   input  wire tsc_pkg::tsc_mode_t mode,
   input  wire logic            mode_wr,
   output logic                 conv_start,
   output logic                 conv_active
);
   import tsc_pkg::*;

   tsc_seq_state_t state_r;
   logic [31:0]    cnt_r;
   logic           kick_r;
   logic [31:0]    conv_len;

   // Window length for the running mode
   always_comb begin
      unique case (mode)
         TSC_MODE_ONESHOT: conv_len = ONESHOT_CYC;
         TSC_MODE_SPS:     conv_len = SPS_CYC;
         default:          conv_len = CONT_CYC;
      endcase
   end

   // Mode state machine and window timer
   always_ff @(posedge clk) begin
      conv_start <= 1'b0;
      if (reset) begin
         state_r <= TSC_SEQ_OFF;
         cnt_r   <= 32'h0;
         kick_r  <= 1'b1;
      end else if (mode_wr || mode == TSC_MODE_SHUTDN) begin
         state_r <= TSC_SEQ_OFF;
         cnt_r   <= 32'h0;
         kick_r  <= 1'b1;
      end else begin
         unique case (state_r)
            TSC_SEQ_OFF: if (kick_r) begin
               kick_r     <= 1'b0;
               state_r    <= TSC_SEQ_CONV;
               conv_start <= 1'b1;
               cnt_r      <= 32'h0;
            end
            TSC_SEQ_CONV: if (cnt_r >= conv_len - 32'h1) begin
               if (mode == TSC_MODE_CONT) begin
                  conv_start <= 1'b1;
                  cnt_r      <= 32'h0;
               end else if (mode == TSC_MODE_SPS) begin
                  state_r <= TSC_SEQ_REST;
                  cnt_r   <= cnt_r + 32'h1;
               end else begin
                  state_r <= TSC_SEQ_OFF;
               end
            end else begin
               cnt_r <= cnt_r + 32'h1;
            end
            TSC_SEQ_REST: if (cnt_r >= PERIOD_CYC - 32'h1) begin
               state_r    <= TSC_SEQ_CONV;
               conv_start <= 1'b1;
               cnt_r      <= 32'h0;
            end else begin
               cnt_r <= cnt_r + 32'h1;
            end
            default: state_r <= TSC_SEQ_OFF;
         endcase
      end
   end

   // Engine power level
   always_ff @(posedge clk) begin
      if (reset) conv_active <= 1'b0;
      else conv_active <= (state_r == TSC_SEQ_CONV) && !mode_wr && mode != TSC_MODE_SHUTDN;
   end

endmodule // tsc_conv_seq

// ### logic/tsc_status_config.sv
// Status flags, configuration register, fault queues and alarm pins
// of the temperature sensor.
// Assumes register accesses come from the serial interface logic on clk,
// and results and limits come from the conversion and setpoint logic.
`timescale 1ns/1ps
`include "tsc_status_map.svh"
module tsc_status_config #(
   parameter int unsigned CONT_CONV_CYC = `TSC_CONT_CONV_MS * `TSC_CLK_KHZ,
   parameter int unsigned ONESHOT_CYC   = `TSC_ONESHOT_MS * `TSC_CLK_KHZ,
   parameter int unsigned SPS_CONV_CYC  = `TSC_SPS_CONV_MS * `TSC_CLK_KHZ,
   parameter int unsigned SPS_PERIOD_CYC = `TSC_SPS_PERIOD_MS * `TSC_CLK_KHZ,
   parameter int unsigned FQ_W          = 3
) (
   input  wire logic               clk,
   input  wire logic               reset,
   input  wire logic [7:0]         reg_addr,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   input  wire logic [7:0]         reg_wdata,
   output logic [7:0]              reg_rdata,
   output logic                    reg_hit,
   input  wire logic               result_wr,
   input  wire logic [15:0]        temp_value,
   input  wire tsc_pkg::tsc_limits_t limits,
   output logic                    conv_start,
   output logic                    conv_active,
   output logic                    res16,
   output logic [2:0]              temp_lsb_bits,
   output logic [7:0]              status_view,
   output logic                    critical_alarm_out,
   output logic                    critical_alarm_oe_n,
   output logic                    limit_alarm_out,
   output logic                    limit_alarm_oe_n
);
   import tsc_pkg::*;

   // Channel numbering for the two alarm paths
   localparam int CH_LIMIT = 0;
   localparam int CH_CRIT  = 1;

   tsc_cfg_t           cfg_r;
   logic               low_flag_r;
   logic               high_flag_r;
   logic               critical_limit_flag_r;
   logic               ready_n_r;
   logic [1:0]         alarm_r;
   logic               cfg_wr;
   logic               status_rd;
   logic               temp_rd;
   logic               seq_start;
   logic               seq_active;
   logic signed [16:0] t_s;
   logic signed [16:0] hi_s;
   logic signed [16:0] lo_s;
   logic signed [16:0] cr_s;
   logic signed [16:0] hy_s;
   logic               below_low;
   logic               above_high;
   logic               above_crit;
   logic               low_back;
   logic               high_back;
   logic               crit_back;
   logic [1:0]         ch_out;
   logic [1:0]         ch_inside;
   logic [FQ_W-1:0]    fq_need;
   tsc_cfg_t           cfg_new;
   logic [7:0]         status_byte;
   logic [2:0]         res_lsb_r;

   // Register access decode
   assign cfg_wr    = reg_wr && (reg_addr == `TSC_REG_CONFIG);
   assign status_rd = reg_rd && (reg_addr == `TSC_REG_STATUS);
   assign temp_rd   = reg_rd && ((reg_addr == `TSC_REG_TEMP_MSB) ||
                                 (reg_addr == `TSC_REG_TEMP_LSB));
   assign cfg_new   = tsc_cfg_t'(reg_wdata);

   // Widen to 17 bits so limit plus hysteresis cannot wrap
   assign t_s  = {temp_value[15], temp_value};
   assign hi_s = {limits.high[15], limits.high};
   assign lo_s = {limits.low[15], limits.low};
   assign cr_s = {limits.crit[15], limits.crit};
   assign hy_s = 17'(limits.hysteresis_value) << `TSC_HYST_SHIFT;

   // Limit compares on the fresh result
   assign below_low  = t_s < lo_s;
   assign above_high = t_s > hi_s;
   assign above_crit = t_s > cr_s;

   // Release thresholds include hysteresis
   assign low_back  = t_s > (lo_s + hy_s);
   assign high_back = t_s < (hi_s - hy_s);
   assign crit_back = t_s < (cr_s - hy_s);

   // Per-channel fault and release conditions
   assign ch_out[CH_LIMIT]    = below_low || above_high;
   assign ch_out[CH_CRIT]     = above_crit;
   assign ch_inside[CH_LIMIT] = low_back && high_back;
   assign ch_inside[CH_CRIT]  = crit_back;

   // Faults required before an alarm: code plus one
   assign fq_need = FQ_W'(cfg_r.fault_q) + FQ_W'(1);

   // Status byte as read back, low nibble reads zero
   assign status_byte = {ready_n_r, critical_limit_flag_r, high_flag_r,
                         low_flag_r, 4'h0};

   // Configuration register, stays writable in every mode
   always_ff @(posedge clk) begin
      if (reset) cfg_r <= tsc_cfg_t'(`TSC_CONFIG_RESET);
      else if (cfg_wr) cfg_r <= cfg_new;
   end

   // Low flag: set on result below limit, set beats clear
   always_ff @(posedge clk) begin
      if (reset) begin
         low_flag_r <= 1'b0;
      end else if (result_wr && below_low) begin
         low_flag_r <= 1'b1;
      end else if (status_rd || (result_wr && low_back)) begin
         low_flag_r <= 1'b0;
      end
   end

   // High flag: set above limit, clear on read or recovery
   always_ff @(posedge clk) begin
      if (reset) begin
         high_flag_r <= 1'b0;
      end else if (result_wr && above_high) begin
         high_flag_r <= 1'b1;
      end else if (status_rd || (result_wr && high_back)) begin
         high_flag_r <= 1'b0;
      end
   end

   // Critical flag: set above limit, clear on read or recovery
   always_ff @(posedge clk) begin
      if (reset) begin
         critical_limit_flag_r <= 1'b0;
      end else if (result_wr && above_crit) begin
         critical_limit_flag_r <= 1'b1;
      end else if (status_rd || (result_wr && crit_back)) begin
         critical_limit_flag_r <= 1'b0;
      end
   end

   // Active-low ready bit: a new result wins over any release
   always_ff @(posedge clk) begin
      if (reset) begin
         ready_n_r <= `TSC_READY_N_RESET;
      end else if (result_wr) begin
         ready_n_r <= 1'b0;
      end else if (temp_rd) begin
         ready_n_r <= 1'b1;
      end else if (cfg_wr && (cfg_new.mode == TSC_MODE_ONESHOT ||
                              cfg_new.mode == TSC_MODE_SPS)) begin
         ready_n_r <= 1'b1;
      end
   end

   // Fault queue and alarm state, one copy per channel
   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_alarm
         logic [FQ_W-1:0] fcnt_r;

         // Consecutive out-of-limit results, saturating at the need
         always_ff @(posedge clk) begin
            if (reset) begin
               fcnt_r <= '0;
            end else if (result_wr) begin
               if (!ch_out[ch]) fcnt_r <= '0;
               else if (fcnt_r < fq_need) fcnt_r <= fcnt_r + FQ_W'(1);
            end
         end

         // Alarm: raised at the fault count, released by mode
         always_ff @(posedge clk) begin
            if (reset) begin
               alarm_r[ch] <= 1'b0;
            end else if (result_wr && ch_out[ch] &&
                         (fcnt_r + FQ_W'(1) >= fq_need)) begin
               alarm_r[ch] <= 1'b1;
            end else if (cfg_r.cmp_mode) begin
               if (result_wr && ch_inside[ch]) alarm_r[ch] <= 1'b0;
            end else if (status_rd) begin
               alarm_r[ch] <= 1'b0;
            end
         end
      end
   endgenerate

   // Open-drain pins: pulled low when asserted level differs from idle
   always_ff @(posedge clk) begin
      if (reset) begin
         critical_alarm_oe_n <= 1'b1;
         limit_alarm_oe_n    <= 1'b1;
      end else begin
         critical_alarm_oe_n <= ~(alarm_r[CH_CRIT] ^ cfg_r.crit_pol);
         limit_alarm_oe_n    <= ~(alarm_r[CH_LIMIT] ^ cfg_r.limit_pol);
      end
   end

   // Pin data is always low; only the enable moves
   always_ff @(posedge clk) begin
      critical_alarm_out <= 1'b0;
      limit_alarm_out    <= 1'b0;
   end

   // Register read data, captured before the read clears flags
   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
         reg_hit   <= 1'b0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `TSC_REG_STATUS: begin
               reg_rdata <= status_byte;
               reg_hit   <= 1'b1;
            end
            `TSC_REG_CONFIG: begin
               reg_rdata <= cfg_r;
               reg_hit   <= 1'b1;
            end
            default: begin
               reg_rdata <= 8'h00;
               reg_hit   <= 1'b0;
            end
         endcase
      end else begin
         reg_hit <= 1'b0;
      end
   end

   // Status view for the serial logic
   always_ff @(posedge clk) begin
      if (reset) status_view <= {`TSC_READY_N_RESET, 7'h00};
      else status_view <= status_byte;
   end

   // Low result bits held from the last written result only
   always_ff @(posedge clk) begin
      if (reset) res_lsb_r <= 3'h0;
      else if (result_wr) res_lsb_r <= temp_value[2:0];
   end

   // Resolution select and low result bits for the value register
   always_ff @(posedge clk) begin
      if (reset) begin
         res16         <= 1'b0;
         temp_lsb_bits <= 3'h0;
      end else begin
         res16 <= cfg_r.res16;
         if (cfg_r.res16) temp_lsb_bits <= res_lsb_r;
         else temp_lsb_bits <= {critical_limit_flag_r, high_flag_r, low_flag_r};
      end
   end

   // Conversion pacing per operating mode
   tsc_conv_seq #(
      .CONT_CYC    (CONT_CONV_CYC),
      .ONESHOT_CYC (ONESHOT_CYC),
      .SPS_CYC     (SPS_CONV_CYC),
      .PERIOD_CYC  (SPS_PERIOD_CYC)
   ) u_seq (
      .clk         (clk),
      .reset       (reset),
      .mode        (cfg_r.mode),
      .mode_wr     (cfg_wr),
      .conv_start  (seq_start),
      .conv_active (seq_active)
   );

   // Retimed sequencer outputs
   always_ff @(posedge clk) begin
      if (reset) begin
         conv_start  <= 1'b0;
         conv_active <= 1'b0;
      end else begin
         conv_start  <= seq_start;
         conv_active <= seq_active;
      end
   end

endmodule // tsc_status_config

// ### sim/tsc_status_config_asserts.sv
// Port checker for the status and configuration block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module tsc_status_config_asserts
   import tsc_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_rd,
   input wire logic        result_wr,
   input wire logic [15:0] temp_value,
   input wire tsc_limits_t limits,
   input wire logic [7:0]  status_view
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // Signed compares of the result against limits and release points
   wire logic signed [15:0] hy = {5'h00, limits.hysteresis_value, 7'h00};
   wire logic signed [15:0] tv = temp_value;
   wire logic t_lo   = tv < $signed(limits.low);
   wire logic t_hi   = tv > $signed(limits.high);
   wire logic t_cr   = tv > $signed(limits.crit);
   wire logic lo_rel = tv > $signed(limits.low) + hy;
   wire logic cr_rel = tv < $signed(limits.crit) - hy;
   wire logic st_rd  = reg_rd && reg_addr == 8'h02;
   wire logic tp_rd  = reg_rd && reg_addr < 8'h02;

   a_low_set: assert property (result_wr && t_lo |-> ##[1:2] status_view[4])
      else $error("low flag not set");
   a_high_set: assert property (result_wr && t_hi |-> ##[1:2] status_view[5])
      else $error("high flag not set");
   a_crit_set: assert property (result_wr && t_cr |-> ##[1:2] status_view[6])
      else $error("critical flag not set");
   a_low_release: assert property (result_wr && lo_rel |-> ##[1:2] !status_view[4])
      else $error("low flag not released");
   a_crit_release: assert property (result_wr && cr_rel |-> ##[1:2] !status_view[6])
      else $error("critical flag not released");
   a_read_clears: assert property (st_rd && !result_wr ##1 !result_wr |-> ##[0:1] status_view[6:4] == 3'h0)
      else $error("status read left flags set");
   a_ready_drop: assert property (result_wr |-> ##[1:2] !status_view[7])
      else $error("ready bit did not drop");
   a_reset_ready: assert property ($fell(reset) |-> status_view == 8'h80)
      else $error("status not at reset value");
   a_temp_rd_ready: assert property (tp_rd && !result_wr ##1 !result_wr |-> ##[0:1] status_view[7])
      else $error("temperature read left ready low");

   // Main scenarios reached
   c_crit: cover property (result_wr && t_cr);
   c_status_rd: cover property (st_rd);
   c_temp_rd: cover property (tp_rd);
endmodule // tsc_status_config_asserts

bind tsc_status_config tsc_status_config_asserts u_tsc_status_config_asserts (
   .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_rd(reg_rd), .result_wr(result_wr),
   .temp_value(temp_value), .limits(limits), .status_view(status_view));

// ### sim/tsc_host_model.sv
// Host side model: register accesses and result delivery.
// Assumes inputs of the block are sampled on the rising clock edge.
`timescale 1ns/1ps
module tsc_host_model
   import tsc_pkg::*;
(
   input  wire logic        clk,
   output logic [7:0]       reg_addr,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic [7:0]       reg_wdata,
   input  wire logic [7:0]  reg_rdata,
   input  wire logic        reg_hit,
   output logic             result_wr,
   output logic [15:0]      temp_value,
   output tsc_limits_t      limits
);
   // Idle levels and power-on setpoints at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h5a;
      result_wr = 1'b0;
      temp_value = 16'ha5a5;
      limits = '{16'h2000, 16'h0500, 16'h4980, 4'h5};
   end

   // One-cycle write; released data shows the inverse, not a stale value
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask

   // One-cycle read; answer taken right after the edge that took it
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic hit);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      d = reg_rdata;
      hit = reg_hit;
   endtask

   // New setpoints, changed off the sampling edge
   task automatic set_lim(input tsc_limits_t l);
      @(negedge clk);
      limits = l;
   endtask

   // One result pulse; value is scrambled once the pulse is over
   task automatic push(input logic [15:0] t);
      @(negedge clk);
      temp_value = t;
      result_wr = 1'b1;
      @(negedge clk);
      result_wr = 1'b0;
      temp_value = ~t;
   endtask
endmodule // tsc_host_model

// ### sim/tsc_status_config_tb_top.sv
// Self-checking bench for the status and configuration block.
// Assumes the host model drives every input but clk and reset; short conversion counts.
`timescale 1ns/1ps
module tsc_status_config_tb_top;
   import tsc_pkg::*;
   logic clk, reset, reg_wr, reg_rd, reg_hit, result_wr, conv_start, conv_active, res16;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, status_view, d;
   logic [15:0] temp_value;
   logic [2:0]  temp_lsb_bits;
   logic        ca_o, ca_n, la_o, la_n, h;
   tsc_limits_t limits;
   int          error_cnt = 0, compares = 0, cyc = 0, n, a;

   tsc_host_model u_tsc_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
      .result_wr(result_wr), .temp_value(temp_value), .limits(limits));

   tsc_status_config #(.CONT_CONV_CYC(20), .ONESHOT_CYC(20), .SPS_CONV_CYC(5),
      .SPS_PERIOD_CYC(40)) u_tsc_status_config (.clk(clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_hit(reg_hit), .result_wr(result_wr),
      .temp_value(temp_value), .limits(limits), .conv_start(conv_start),
      .conv_active(conv_active), .res16(res16), .temp_lsb_bits(temp_lsb_bits),
      .status_view(status_view), .critical_alarm_out(ca_o), .critical_alarm_oe_n(ca_n),
      .limit_alarm_out(la_o), .limit_alarm_oe_n(la_n));

   // Clock at 50 MHz
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Cuts a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         stop_test();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic settle(input int k);
      repeat (k) @(negedge clk);
   endtask

   // Result, then status byte and low byte bits one cycle later
   task automatic push_st(input logic [15:0] t, input logic [7:0] s);
      u_tsc_host_model.push(t);
      settle(1);
      chk(status_view, s);
      chk(temp_lsb_bits, s[6:4]);
   endtask

   // Result, then both pin levels {critical, limit}
   task automatic push_pin(input logic [15:0] t, input logic [1:0] p);
      u_tsc_host_model.push(t);
      settle(1);
      chk({ca_n, la_n}, p);
   endtask

   // Counts start pulses and active cycles over a span
   task automatic count(input int c);
      n = 0;
      a = 0;
      repeat (c) begin
         n += int'(conv_start === 1'b1);
         a += int'(conv_active === 1'b1);
         @(negedge clk);
      end
   endtask

   task automatic t_reset;
      u_tsc_host_model.rd_reg(8'h02, d, h);
      chk({h, d}, 9'h180);
      u_tsc_host_model.rd_reg(8'h03, d, h);
      chk(d, 8'h00);
      u_tsc_host_model.wr_reg(8'h02, 8'hff);
      u_tsc_host_model.rd_reg(8'h0b, d, h);
      chk({h, d}, 9'h000);
      settle(1);
      chk(status_view, 8'h80);
      $display("test reset done");
   endtask

   task automatic t_flags;
      push_st(16'h2100, 8'h20);
      push_st(16'h1e00, 8'h20);
      push_st(16'h1d00, 8'h00);
      push_st(16'h4a00, 8'h60);
      push_st(16'h4800, 8'h60);
      push_st(16'h4600, 8'h20);
      push_st(16'h0400, 8'h10);
      push_st(16'h0700, 8'h10);
      push_st(16'h0800, 8'h00);
      u_tsc_host_model.push(16'h4a00);
      u_tsc_host_model.rd_reg(8'h02, d, h);
      chk(d, 8'h60);
      settle(1);
      chk(status_view, 8'h00);
      u_tsc_host_model.rd_reg(8'h01, d, h);
      settle(1);
      chk(status_view, 8'h80);
      u_tsc_host_model.set_lim('{16'h1000, 16'hff00, 16'h3000, 4'h0});
      push_st(16'hfe00, 8'h10);
      push_st(16'hff80, 8'h00);
      push_st(16'h1080, 8'h20);
      push_st(16'h0f80, 8'h00);
      u_tsc_host_model.set_lim('{16'h2000, 16'h0500, 16'h4980, 4'h5});
      $display("test flags done");
   endtask

   task automatic t_alarm;
      u_tsc_host_model.wr_reg(8'h03, 8'h0e);
      u_tsc_host_model.rd_reg(8'h02, d, h);
      settle(1);
      chk({ca_n, la_n}, 2'b00);
      chk({ca_o, la_o}, 2'b00);
      push_pin(16'h4a00, 2'b00);
      push_pin(16'h4a00, 2'b00);
      push_pin(16'h1000, 2'b00);
      push_pin(16'h4a00, 2'b00);
      push_pin(16'h4a00, 2'b00);
      push_pin(16'h4a00, 2'b11);
      settle(3);
      chk({ca_n, la_n}, 2'b11);
      u_tsc_host_model.rd_reg(8'h02, d, h);
      settle(1);
      chk({ca_n, la_n}, 2'b00);
      u_tsc_host_model.wr_reg(8'h03, 8'h13);
      push_pin(16'h1000, 2'b11);
      push_pin(16'h0400, 2'b11);
      push_pin(16'h0400, 2'b11);
      push_pin(16'h0400, 2'b11);
      push_pin(16'h0400, 2'b10);
      u_tsc_host_model.rd_reg(8'h02, d, h);
      settle(1);
      chk({ca_n, la_n}, 2'b10);
      push_pin(16'h0700, 2'b10);
      push_pin(16'h0800, 2'b11);
      $display("test alarm done");
   endtask

   task automatic t_modes;
      u_tsc_host_model.wr_reg(8'h03, 8'h60);
      settle(4);
      count(60);
      chk({n[7:0], a[7:0]}, 16'h0000);
      u_tsc_host_model.rd_reg(8'h03, d, h);
      chk({h, d}, 9'h160);
      u_tsc_host_model.push(16'h0900);
      u_tsc_host_model.wr_reg(8'h03, 8'h20);
      count(100);
      chk(n, 1);
      chk(a >= 15 && a <= 25, 1'b1);
      chk(status_view[7], 1'b1);
      u_tsc_host_model.push(16'h0900);
      u_tsc_host_model.wr_reg(8'h03, 8'h40);
      count(200);
      chk(n >= 4 && n <= 6, 1'b1);
      chk(a >= 20 && a <= 35, 1'b1);
      chk(status_view[7], 1'b1);
      u_tsc_host_model.push(16'h0900);
      u_tsc_host_model.wr_reg(8'h03, 8'h00);
      count(200);
      chk(n >= 9 && n <= 11, 1'b1);
      chk(a >= 180, 1'b1);
      chk(status_view[7], 1'b0);
      u_tsc_host_model.wr_reg(8'h03, 8'h80);
      settle(2);
      chk(res16, 1'b1);
      u_tsc_host_model.push(16'h2105);
      settle(1);
      chk(temp_lsb_bits, 3'h5);
      chk(status_view, 8'h20);
      $display("test modes done");
   endtask

   task automatic stop_test;
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Reset for six cycles, then the scenarios
   initial begin
      reset = 1'b1;
      settle(6);
      reset = 1'b0;
      t_reset();
      t_flags();
      t_alarm();
      t_modes();
      stop_test();
   end
endmodule // tsc_status_config_tb_top
